// >>> stsr_map.svh
// constants for the system trap and service request block
`ifndef STSR_MAP_SVH
`define STSR_MAP_SVH
`define STSR_NREQ        13
// raw request bit positions
`define STSR_B_PREWARN   0
`define STSR_B_PERIODIC  1
`define STSR_B_ALARM     2
`define STSR_B_OVERRUN   3
`define STSR_B_HIBWDG    4
`define STSR_B_MIRR0     5
// trap status bit positions
`define STSR_T_PLLWDG    0
`define STSR_T_LOCKLOSS  1
`define STSR_T_PARITY    2
`define STSR_NTRAP       3
// parity test targets
`define STSR_NTGT        5
`define STSR_PAR_W       4
// test memory depth, as address bits
`define STSR_DEPTH_LOG2  6
`endif

// >>> stsr_pkg.sv
// types for the system trap and service request block
package stsr_pkg;
    typedef enum logic [1:0] {
        STSR_RUN   = 2'b00,
        STSR_ENTER = 2'b01,
        STSR_SLEEP = 2'b10
    } stsr_sleep_t;

    typedef struct packed {
        logic        wr;
        logic [5:0]  addr;
        logic [31:0] data;
        logic        rd;
    } stsr_mem_req_t;
endpackage

// >>> stsr_parity_mem.sv
// one test memory with stored parity and parity implant
`timescale 1ns/1ps
`default_nettype none
module stsr_parity_mem #(
    parameter int AW = 6,
    parameter int PW = 4
) (
    input  wire logic                  SYS_CLK_I,
    input  wire logic                  RESET_N_I,
    input  wire stsr_pkg::stsr_mem_req_t req_i,
    input  wire logic                  implant_i,
    input  wire logic [PW-1:0]         par_val_i,
    output logic [31:0]                rdata_o,
    output logic [PW-1:0]              rpar_o,
    output logic                       perr_o
);
    logic [31:0]   mem [0:(1<<AW)-1];
    logic [PW-1:0] par [0:(1<<AW)-1];
    logic [PW-1:0] wpar;
    logic [PW-1:0] cpar;
    logic [31:0]   rd_reg;
    logic [PW-1:0] rp_reg;
    logic          rv_reg;

    function automatic logic [PW-1:0] calc(input logic [31:0] d);
        logic [PW-1:0] p;
        p = '0;
        for (int i = 0; i < 32; i++) begin
            p[i % PW] = p[i % PW] ^ d[i];
        end
        return p;
    endfunction

    assign wpar = implant_i ? par_val_i : calc(req_i.data);
    assign cpar = calc(rd_reg);

    always_ff @(posedge SYS_CLK_I) begin
        if (req_i.wr) begin
            mem[req_i.addr] <= req_i.data;
            par[req_i.addr] <= wpar;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RESET_N_I) begin
            rd_reg <= 32'h0;
            rp_reg <= '0;
            rv_reg <= 1'b0;
        end else begin
            rv_reg <= req_i.rd;
            if (req_i.rd) begin
                rd_reg <= mem[req_i.addr];
                rp_reg <= par[req_i.addr];
            end
        end
    end

    assign rdata_o = rd_reg;
    assign rpar_o  = rp_reg;
    assign perr_o  = rv_reg && (cpar != rp_reg);
endmodule // stsr_parity_mem
`default_nettype wire

// >>> stsr_top.sv
// service request register, trap gating and parity test control
//
// Function
// - pll power-down deep sleep entry may raise pll watchdog and lock traps.
// - any enabled pll or lock trap, or a parity trap of a selected target, during deep sleep entry wakes the device at once.
// - the trap disable bits suppress the pll watchdog and lock loss traps.
// - software can implant parity bits and read stored parity back.
// - the parity readback may be wrong and is not trusted by tests.
// - one parity test target is selected, with error and trap enabled.
// - the implant value goes with the next write to the selected memory.
// - a read with conflicting parity sets a parity error flag and nmi trap.
// - a clear write during hardware requests loses those requests.
// - the loss only happens when cleared bits differ from requested bits.
// - ones written to the clear register clear raw request bits.
// - ones written to the set register set raw request bits.
// - the status register shows requests flagged for servicing.
// - each raw request bit follows one primary hardware source.
`timescale 1ns/1ps
`default_nettype none
`include "stsr_map.svh"
module stsr_top #(
    parameter int NREQ  = `STSR_NREQ,
    parameter int NTGT  = `STSR_NTGT,
    parameter int PW    = `STSR_PAR_W,
    parameter int AW    = `STSR_DEPTH_LOG2
) (
    input  wire logic                   SYS_CLK_I,
    input  wire logic                   RESET_N_I,
    // hardware request sources
    input  wire logic [NREQ-1:0]        HW_REQ_I,
    input  wire logic                   REQ_CLEAR_WR_I,
    input  wire logic [NREQ-1:0]        REQ_CLEAR_DATA_I,
    input  wire logic                   REQ_SET_WR_I,
    input  wire logic [NREQ-1:0]        REQ_SET_DATA_I,
    input  wire logic [NREQ-1:0]        REQ_MASK_I,
    output logic [NREQ-1:0]             RAW_REQUEST_O,
    output logic [NREQ-1:0]             REQUEST_STATUS_O,
    // deep sleep and pll traps
    input  wire logic                   SLEEP_REQ_I,
    input  wire logic                   PLL_POWERDOWN_I,
    input  wire logic                   PLL_WDG_EVENT_I,
    input  wire logic                   LOCK_LOSS_EVENT_I,
    input  wire logic [1:0]             TRAP_DISABLE_I,
    output logic                        DEEP_SLEEP_O,
    // parity test
    input  wire logic                   PARITY_ERROR_ENABLE_I,
    input  wire logic                   PARITY_TRAP_ENABLE_I,
    input  wire logic [NTGT-1:0]        TEST_SELECT_I,
    input  wire logic                   MEM_CHECK_ENABLE_I,
    input  wire logic                   PWR_WR_I,
    input  wire logic [PW-1:0]          PWR_DATA_I,
    output logic [PW-1:0]               PARITY_READBACK_O,
    input  wire logic [NTGT-1:0]        MEM_WR_I,
    input  wire logic [NTGT-1:0]        MEM_RD_I,
    input  wire logic [AW-1:0]          MEM_ADDR_I,
    input  wire logic [31:0]            MEM_WDATA_I,
    output logic [31:0]                 MEM_RDATA_O,
    output logic [NTGT-1:0]             PARITY_ERROR_FLAGS_O,
    input  wire logic [NTGT-1:0]        PARITY_FLAG_CLR_I,
    output logic [`STSR_NTRAP-1:0]      TRAP_STATUS_O,
    input  wire logic [`STSR_NTRAP-1:0] TRAP_CLR_I,
    output logic                        NMI_O
);
    typedef struct packed {
        logic [NREQ-1:0]         raw;
        stsr_pkg::stsr_sleep_t   sleep;
        logic [PW-1:0]           pwr;
        logic                    armed;
        logic [PW-1:0]           prd;
        logic [NTGT-1:0]         pflag;
        logic [`STSR_NTRAP-1:0]  trap;
        logic [31:0]             rdata;
        logic [NTGT-1:0]         rd_dly;
    } stsr_state_t;

    stsr_state_t state_reg;
    stsr_state_t state_next;

    logic [NTGT-1:0]   perr;
    logic [NTGT-1:0]   implant;
    logic [NTGT*32-1:0] rd_all;
    logic [NTGT*PW-1:0] rp_all;
    logic              sel_one;
    logic [NREQ-1:0]   lost;
    logic              pll_trap;
    logic              lock_trap;
    logic              any_trap;

    ////////////////////////////////////////////////////////////////////////
    // test memories, one per target
    assign sel_one = MEM_CHECK_ENABLE_I && $onehot(TEST_SELECT_I);

    for (genvar g = 0; g < NTGT; g++) begin : g_mem
        stsr_pkg::stsr_mem_req_t mreq;
        assign mreq.wr   = MEM_WR_I[g];
        assign mreq.rd   = MEM_RD_I[g];
        assign mreq.addr = MEM_ADDR_I;
        assign mreq.data = MEM_WDATA_I;
        // implant only on the first write after arming, selected target
        assign implant[g] = sel_one && TEST_SELECT_I[g] && state_reg.armed;
        stsr_parity_mem #(
            .AW (AW),
            .PW (PW)
        ) u_mem (
            .SYS_CLK_I (SYS_CLK_I),
            .RESET_N_I (RESET_N_I),
            .req_i     (mreq),
            .implant_i (implant[g]),
            .par_val_i (state_reg.pwr),
            .rdata_o   (rd_all[g*32 +: 32]),
            .rpar_o    (rp_all[g*PW +: PW]),
            .perr_o    (perr[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // trap sources
    always_comb begin
        pll_trap  = PLL_WDG_EVENT_I && !TRAP_DISABLE_I[`STSR_T_PLLWDG];
        lock_trap = LOCK_LOSS_EVENT_I &&
                    !TRAP_DISABLE_I[`STSR_T_LOCKLOSS];
        any_trap  = pll_trap || lock_trap || (|(perr & TEST_SELECT_I) &&
                    PARITY_TRAP_ENABLE_I && PARITY_ERROR_ENABLE_I);
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        state_next = state_reg;
        // known defect kept: a differing clear swallows new requests
        lost = (REQ_CLEAR_WR_I && (REQ_CLEAR_DATA_I != HW_REQ_I)) ?
               HW_REQ_I : '0;
        state_next.raw = state_reg.raw | (HW_REQ_I & ~lost);
        if (REQ_CLEAR_WR_I) begin
            state_next.raw = state_next.raw & ~REQ_CLEAR_DATA_I;
        end
        if (REQ_SET_WR_I) begin
            state_next.raw = state_next.raw | REQ_SET_DATA_I;
        end

        case (state_reg.sleep)
            stsr_pkg::STSR_RUN: begin
                if (SLEEP_REQ_I) begin
                    state_next.sleep = stsr_pkg::STSR_ENTER;
                end
            end
            stsr_pkg::STSR_ENTER: begin
                // pll power-down glitches show up as traps here
                if (any_trap) begin
                    state_next.sleep = stsr_pkg::STSR_RUN;
                end else begin
                    state_next.sleep = stsr_pkg::STSR_SLEEP;
                end
            end
            stsr_pkg::STSR_SLEEP: begin
                if (any_trap || !SLEEP_REQ_I) begin
                    state_next.sleep = stsr_pkg::STSR_RUN;
                end
            end
            default: state_next.sleep = stsr_pkg::STSR_RUN;
        endcase

        if (PWR_WR_I) begin
            state_next.pwr   = PWR_DATA_I;
            state_next.armed = 1'b1;
        end else if (|(MEM_WR_I & TEST_SELECT_I) && sel_one) begin
            state_next.armed = 1'b0;
        end

        // readback sampled in the strobe cycle, one cycle early: may show stale parity
        state_next.prd = state_reg.prd;
        // memory data lands one cycle after its strobe, so take it then
        state_next.rd_dly = MEM_RD_I;
        for (int i = 0; i < NTGT; i++) begin
            if (TEST_SELECT_I[i] && MEM_RD_I[i]) begin
                state_next.prd = rp_all[i*PW +: PW];
            end
            if (state_reg.rd_dly[i]) begin
                state_next.rdata = rd_all[i*32 +: 32];
            end
        end

        // set wins over clear on the parity error flags and trap status bits
        state_next.pflag = (state_reg.pflag & ~PARITY_FLAG_CLR_I) |
                           (PARITY_ERROR_ENABLE_I ? perr : '0);
        state_next.trap = state_reg.trap & ~TRAP_CLR_I;
        if (pll_trap) begin
            state_next.trap[`STSR_T_PLLWDG] = 1'b1;
        end
        if (lock_trap) begin
            state_next.trap[`STSR_T_LOCKLOSS] = 1'b1;
        end
        if (PARITY_ERROR_ENABLE_I && PARITY_TRAP_ENABLE_I && |perr) begin
            state_next.trap[`STSR_T_PARITY] = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RESET_N_I) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign RAW_REQUEST_O        = state_reg.raw;
    assign REQUEST_STATUS_O     = state_reg.raw & REQ_MASK_I;
    assign DEEP_SLEEP_O         = state_reg.sleep == stsr_pkg::STSR_SLEEP;
    assign PARITY_READBACK_O    = state_reg.prd;
    assign MEM_RDATA_O          = state_reg.rdata;
    assign PARITY_ERROR_FLAGS_O = state_reg.pflag;
    assign TRAP_STATUS_O        = state_reg.trap;
    assign NMI_O                = state_reg.trap[`STSR_T_PARITY];
endmodule // stsr_top
`default_nettype wire

// >>> stsr_chk.sv
// checker on the service request, sleep and trap ports
`timescale 1ns/1ps
`default_nettype none
`include "stsr_map.svh"
module stsr_chk #(
    parameter int NREQ = `STSR_NREQ
) (
    input wire logic                   SYS_CLK_I,
    input wire logic                   RESET_N_I,
    input wire logic [NREQ-1:0]        HW_REQ_I,
    input wire logic                   REQ_CLEAR_WR_I,
    input wire logic [NREQ-1:0]        REQ_CLEAR_DATA_I,
    input wire logic                   REQ_SET_WR_I,
    input wire logic [NREQ-1:0]        REQ_SET_DATA_I,
    input wire logic [NREQ-1:0]        REQ_MASK_I,
    input wire logic [NREQ-1:0]        RAW_REQUEST_O,
    input wire logic [NREQ-1:0]        REQUEST_STATUS_O,
    input wire logic                   SLEEP_REQ_I,
    input wire logic                   PLL_WDG_EVENT_I,
    input wire logic                   LOCK_LOSS_EVENT_I,
    input wire logic [1:0]             TRAP_DISABLE_I,
    input wire logic                   DEEP_SLEEP_O,
    input wire logic [`STSR_NTRAP-1:0] TRAP_STATUS_O
);
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    logic trap_en;
    assign trap_en = (PLL_WDG_EVENT_I & ~TRAP_DISABLE_I[0])
                   | (LOCK_LOSS_EVENT_I & ~TRAP_DISABLE_I[1]);
    ////////////////////////////////////////////////////////////////////
    sequence s_clr;
        REQ_CLEAR_WR_I && !REQ_SET_WR_I;
    endsequence
    sequence s_quiet;
        SLEEP_REQ_I && !trap_en;
    endsequence
    property p_set;
        REQ_SET_WR_I |=>
            (RAW_REQUEST_O & $past(REQ_SET_DATA_I)) == $past(REQ_SET_DATA_I);
    endproperty
    a_set: assert property (p_set)
        else $error("set bits missing");
    property p_clr;
        s_clr |=> (RAW_REQUEST_O & $past(REQ_CLEAR_DATA_I)) == '0;
    endproperty
    a_clr: assert property (p_clr)
        else $error("cleared bits still set");
    // the documented defect: unmatched hw requests are dropped
    property p_lost;
        s_clr ##0 (REQ_CLEAR_DATA_I != HW_REQ_I) |=>
            RAW_REQUEST_O == ($past(RAW_REQUEST_O) & ~$past(REQ_CLEAR_DATA_I));
    endproperty
    a_lost: assert property (p_lost)
        else $error("raw bits after clear wrong");
    property p_hw;
        !REQ_CLEAR_WR_I && !REQ_SET_WR_I |=>
            (RAW_REQUEST_O & $past(HW_REQ_I)) == $past(HW_REQ_I);
    endproperty
    a_hw: assert property (p_hw)
        else $error("hw request not registered");
    property p_stat;
        REQUEST_STATUS_O == (RAW_REQUEST_O & REQ_MASK_I);
    endproperty
    a_stat: assert property (p_stat)
        else $error("status not raw and mask");
    property p_trap;
        (PLL_WDG_EVENT_I && !TRAP_DISABLE_I[0] |=> TRAP_STATUS_O[0]) and
        (LOCK_LOSS_EVENT_I && !TRAP_DISABLE_I[1] |=> TRAP_STATUS_O[1]);
    endproperty
    a_trap: assert property (p_trap)
        else $error("enabled trap not flagged");
    property p_dis;
        ($rose(TRAP_STATUS_O[0]) |->
            $past(PLL_WDG_EVENT_I && !TRAP_DISABLE_I[0])) and
        ($rose(TRAP_STATUS_O[1]) |->
            $past(LOCK_LOSS_EVENT_I && !TRAP_DISABLE_I[1]));
    endproperty
    a_dis: assert property (p_dis)
        else $error("trap raised while disabled");
    property p_wake;
        DEEP_SLEEP_O && trap_en |=> !DEEP_SLEEP_O;
    endproperty
    a_wake: assert property (p_wake)
        else $error("trap did not wake");
    property p_enter;
        !SLEEP_REQ_I ##1 s_quiet [*4] |-> DEEP_SLEEP_O;
    endproperty
    a_enter: assert property (p_enter)
        else $error("deep sleep not reached");
    // a trap in the entry cycle must keep the device out of sleep
    property p_abort;
        $rose(SLEEP_REQ_I) ##1 trap_en |=> !DEEP_SLEEP_O;
    endproperty
    a_abort: assert property (p_abort)
        else $error("sleep entered despite entry trap");
endmodule // stsr_chk
bind stsr_top stsr_chk #(.NREQ(NREQ)) u_chk (.*);
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the trap and service request block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        SYS_CLK_I, RESET_N_I, REQ_CLEAR_WR_I, REQ_SET_WR_I;
    logic        SLEEP_REQ_I, PLL_POWERDOWN_I, PLL_WDG_EVENT_I, NMI_O;
    logic        LOCK_LOSS_EVENT_I, PARITY_ERROR_ENABLE_I, DEEP_SLEEP_O;
    logic        PARITY_TRAP_ENABLE_I, MEM_CHECK_ENABLE_I, PWR_WR_I;
    logic [12:0] HW_REQ_I, REQ_CLEAR_DATA_I, REQ_SET_DATA_I, REQ_MASK_I;
    logic [12:0] RAW_REQUEST_O, REQUEST_STATUS_O, exp_raw;
    logic [4:0]  TEST_SELECT_I, MEM_WR_I, MEM_RD_I, PARITY_FLAG_CLR_I;
    logic [4:0]  PARITY_ERROR_FLAGS_O;
    logic [3:0]  PWR_DATA_I, PARITY_READBACK_O;
    logic [5:0]  MEM_ADDR_I;
    logic [31:0] MEM_WDATA_I, MEM_RDATA_O;
    logic [2:0]  TRAP_STATUS_O, TRAP_CLR_I;
    logic [1:0]  TRAP_DISABLE_I;
    int          mismatches = 0;
    int          checks = 0;
    int          cycles = 0;
    stsr_top i_dut (.*);
    always #25 SYS_CLK_I = ~SYS_CLK_I;
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] s, e);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge SYS_CLK_I);
    endtask
    task automatic look;
        @(negedge SYS_CLK_I);
    endtask
    task automatic print_verdict;
        if (mismatches == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // one cycle of hardware requests and register writes
    task automatic req(input logic [12:0] hw, clr, set, input logic cw, sw);
        tick(1);
        {HW_REQ_I, REQ_CLEAR_DATA_I, REQ_SET_DATA_I, REQ_CLEAR_WR_I,
         REQ_SET_WR_I} <= {hw, clr, set, cw, sw};
        tick(1);
        {HW_REQ_I, REQ_CLEAR_WR_I, REQ_SET_WR_I} <= '0;
        look();
    endtask
    task automatic mem(input logic [4:0] wr, rd, input logic [5:0] a);
        tick(1);
        {MEM_WR_I, MEM_RD_I, MEM_ADDR_I} <= {wr, rd, a};
    endtask
    // readback field is unreliable, so only read data, error flags and nmi are judged
    task automatic par(input logic [4:0] sel, tgt, exp);
        tick(1);
        {TEST_SELECT_I, PWR_WR_I} <= {sel, 1'b1};
        mem(tgt, 5'h0, 6'h0);
        PWR_WR_I <= 1'b0;
        mem(tgt, 5'h0, 6'h1);
        mem(5'h0, tgt, 6'h0);
        mem(5'h0, 5'h0, 6'h0);
        tick(2);
        look();
        chk("read data", MEM_RDATA_O, 32'h1);
        chk("parity flags", PARITY_ERROR_FLAGS_O, exp);
        chk("nmi", {TRAP_STATUS_O[2], NMI_O}, {2{|exp}});
        tick(1);
        {PARITY_FLAG_CLR_I, TRAP_CLR_I} <= {5'h1f, 3'h4};
        mem(5'h0, tgt, 6'h1);
        {PARITY_FLAG_CLR_I, TRAP_CLR_I} <= '0;
        mem(5'h0, 5'h0, 6'h0);
        tick(2);
        look();
        chk("flags clean read", {PARITY_ERROR_FLAGS_O, NMI_O}, 6'h0);
    endtask
    task automatic nap(input logic [1:0] dis, input logic [2:0] tr, stay);
        tick(1);
        {TRAP_DISABLE_I, SLEEP_REQ_I} <= {dis, 1'b1};
        tick(4);
        look();
        chk("sleep entered", DEEP_SLEEP_O, 1'b1);
        tick(1);
        {PLL_WDG_EVENT_I, LOCK_LOSS_EVENT_I} <= 2'h3;
        tick(1);
        {PLL_WDG_EVENT_I, LOCK_LOSS_EVENT_I, SLEEP_REQ_I} <= 3'h0;
        look();
        chk("sleep after trap", DEEP_SLEEP_O, stay);
        chk("trap status", TRAP_STATUS_O, tr);
        tick(1);
        TRAP_CLR_I <= 3'h3;
        tick(1);
        TRAP_CLR_I <= 3'h0;
        tick(2);
    endtask
    always @(posedge SYS_CLK_I) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            print_verdict();
        end
    end
    initial begin
        {SYS_CLK_I, RESET_N_I, HW_REQ_I, REQ_CLEAR_DATA_I, REQ_SET_DATA_I,
         REQ_CLEAR_WR_I, REQ_SET_WR_I, SLEEP_REQ_I, PLL_WDG_EVENT_I,
         LOCK_LOSS_EVENT_I, TRAP_DISABLE_I, TEST_SELECT_I, PWR_WR_I,
         MEM_WR_I, MEM_RD_I, MEM_ADDR_I, PARITY_FLAG_CLR_I, TRAP_CLR_I} = '0;
        {PLL_POWERDOWN_I, PARITY_ERROR_ENABLE_I, PARITY_TRAP_ENABLE_I,
         MEM_CHECK_ENABLE_I} = 4'hf;
        REQ_MASK_I = 13'h0a5a;
        PWR_DATA_I = 4'h6;
        MEM_WDATA_I = 32'h1;
        tick(12);
        RESET_N_I <= 1'b1;
        exp_raw = 13'h0;
        for (int i = 0; i < 13; i++) begin
            req(13'h1 << i, 13'h0, 13'h0, 1'b0, 1'b0);
            exp_raw[i] = 1'b1;
            chk("raw", RAW_REQUEST_O, exp_raw);
        end
        chk("status", REQUEST_STATUS_O, 13'h0a5a);
        req(13'h0, 13'h0f0f, 13'h0, 1'b1, 1'b0);
        chk("raw cleared", RAW_REQUEST_O, 13'h10f0);
        req(13'h0, 13'h1fff, 13'h0001, 1'b1, 1'b1);
        chk("set over clear", RAW_REQUEST_O, 13'h0001);
        req(13'h0008, 13'h0001, 13'h0, 1'b1, 1'b0);
        chk("raw lost", RAW_REQUEST_O, 13'h0);
        req(13'h0, 13'h0, 13'h0008, 1'b0, 1'b1);
        chk("raw restored", RAW_REQUEST_O, 13'h0008);
        tick(1);
        REQ_MASK_I <= 13'h1ff7;
        look();
        chk("status masked", REQUEST_STATUS_O, 13'h0);
        nap(2'h3, 3'h0, 1'b1);
        nap(2'h2, 3'h1, 1'b0);
        nap(2'h1, 3'h2, 1'b0);
        // trap arriving in the entry cycle itself
        tick(1);
        {TRAP_DISABLE_I, SLEEP_REQ_I} <= 3'h1;
        tick(1);
        PLL_WDG_EVENT_I <= 1'b1;
        tick(1);
        {PLL_WDG_EVENT_I, SLEEP_REQ_I} <= 2'h0;
        look();
        chk("entry aborted", DEEP_SLEEP_O, 1'b0);
        chk("entry trap", TRAP_STATUS_O, 3'h1);
        tick(1);
        TRAP_CLR_I <= 3'h3;
        tick(1);
        TRAP_CLR_I <= 3'h0;
        for (int t = 0; t < 5; t++) begin
            par(5'h1 << t, 5'h1 << t, 5'h1 << t);
        end
        par(5'h3, 5'h1, 5'h0);
        tick(1);
        MEM_CHECK_ENABLE_I <= 1'b0;
        par(5'h1, 5'h1, 5'h0);
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
